/* rtl/sesm_pkg.sv */
// Constants shared by the stop-exit sequencer and supply monitor
// Behaviour
// - A wake event ending stop restarts clocks and selects reset or interrupt vector.
// - Low external reset pin resets controller and selects vector at FFFE/FFFF; the code selects it only if the reset ends stop.
// - Falling edge on external interrupt pin ends stop, selects vector FFFA/FFFB.
// - Periodic tick rollover ends stop and selects vector FFDC/FFDD.
// - Bus activity wakes from stop; bus receive ignored until oscillator is synchronized.
// - After wake, a 13-bit counter holds system clocks off for 4096 reference cycles.
// - Short-recovery bit shortens the recovery delay to 32 reference cycles.
// - Supply below falling trip point resets the device, selecting vector FFFE/FFFF; the code selects it only if the trip ends stop.
// - Once tripped, reset holds until supply rises above the rising trip point; the code also ends the hold on a pin reset.
// - A configuration bit selects the 5-V or 3-V trip thresholds.
// - Supply-low flag is read-only and sets when supply falls below falling trip.
// - Flag is 0 above rising, 1 below falling, unchanged in between.
// - External pin reset and presetn clear the supply-low flag; a supply reset sets it.
// - Supply monitor raises no interrupt; outputs only reset request and flag. The code sets event bit 5, which drives irq if mask bit 5 is set.
// - Oscillator-enable request enables both oscillator and phase-locked loop.
// - Oscillator-in-stop bit keeps oscillator running in stop; else request controls it.
package sesm_pkg;
   // Register byte offsets
   localparam logic [11:0] SESM_OFS_CONFIG   = 12'h000;
   localparam logic [11:0] SESM_OFS_CONTROL  = 12'h004;
   localparam logic [11:0] SESM_OFS_STATUS   = 12'h008;
   localparam logic [11:0] SESM_OFS_EVENT    = 12'h00C;
   localparam logic [11:0] SESM_OFS_MASK     = 12'h010;
   localparam logic [11:0] SESM_OFS_VECTOR   = 12'h014;
   // Config field positions
   localparam int SESM_CFG_SHORT_REC  = 0;
   localparam int SESM_CFG_TRIP_SEL   = 1;
   localparam int SESM_CFG_OSC_STOP   = 2;
   localparam int SESM_CFG_CAN_WAKE   = 3;
   localparam logic [3:0] SESM_CFG_RESET = 4'h0;
   // Status fields
   localparam int SESM_ST_SUPPLY_LOW  = 7;
   // Event bits: 0 ext reset, 1 irq, 2 kbd, 3 tick, 4 bus, 5 supply reset
   localparam int SESM_EVT_W = 6;
   localparam logic [5:0] SESM_EVT_RESET = 6'h00;
   // Vector addresses (low byte location)
   localparam logic [15:0] SESM_VEC_RESET = 16'hFFFE;
   localparam logic [15:0] SESM_VEC_IRQ   = 16'hFFFA;
   localparam logic [15:0] SESM_VEC_KBD   = 16'hFFE0;
   localparam logic [15:0] SESM_VEC_TICK  = 16'hFFDC;
   localparam logic [15:0] SESM_VEC_BUS   = 16'hFFDA;
   // Recovery counts in reference cycles
   localparam int SESM_REC_FULL  = 4096;
   localparam int SESM_REC_SHORT = 32;
   localparam int SESM_REC_W     = 12;
   typedef enum logic [1:0] {
      SESM_RUN     = 2'b00,
      SESM_STOP    = 2'b01,
      SESM_RECOVER = 2'b10
   } sesm_state_type;
endpackage

/* rtl/sesm_stop_exit.sv */
// Stop-mode exit sequencer with supply monitor and APB register slave
`timescale 1ns/100ps
`default_nettype none
module sesm_stop_exit
   import sesm_pkg::*;
#(
   parameter int REC_FULL  = SESM_REC_FULL,
   parameter int REC_SHORT = SESM_REC_SHORT,
   parameter int KBD_W     = 8
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Asynchronous wake and supply inputs
   input  wire logic              ext_reset_n,
   input  wire logic              ext_irq_n,
   input  wire logic [KBD_W-1:0]  kbd_n,
   input  wire logic              tick_rollover,
   input  wire logic              bus_activity,
   input  wire logic              supply_below_fall_5v,
   input  wire logic              supply_above_rise_5v,
   input  wire logic              supply_below_fall_3v,
   input  wire logic              supply_above_rise_3v,
   // CPU side
   input  wire logic              stop_req,
   input  wire logic              osc_enable_req,
   output logic                   sys_reset,
   output logic                   sys_clk_en,
   output logic                   vector_load,
   output logic      [15:0]       vector_addr,
   output logic                   osc_run,
   output logic                   pll_run,
   output logic                   bus_rx_enable,
   output logic                   irq
);

   localparam int SYNC_W = 6 + KBD_W;

   // Reload value for the recovery counter, counted down to zero
   function automatic logic [SESM_REC_W:0] rec_load(input logic short_sel);
      rec_load = short_sel ? (SESM_REC_W+1)'(REC_SHORT - 1) : (SESM_REC_W+1)'(REC_FULL - 1);
   endfunction

   logic [SYNC_W-1:0]    sync1_reg;
   logic [SYNC_W-1:0]    sync2_reg;
   logic [SYNC_W-1:0]    prev_reg;
   logic [3:0]           cfg_reg;
   logic [SESM_EVT_W-1:0] evt_reg;
   logic [SESM_EVT_W-1:0] mask_reg;
   logic                 supply_low_flag_reg;
   logic                 supply_reset_reg;
   sesm_state_type       state_reg;
   logic [SESM_REC_W:0]  rec_cnt_reg;
   logic [15:0]          vec_reg;
   logic [SESM_EVT_W-1:0] evt_now;
   logic                 rst_s;
   logic                 irq_fall;
   logic                 kbd_fall;
   logic                 tick_s;
   logic                 bus_s;
   logic                 below_s;
   logic                 above_s;
   logic                 any_reset;
   logic                 wake;
   logic                 apb_wr;
   logic                 apb_rd;
   logic                 addr_ok;
   logic [15:0]          vec_next;

   // Two-stage synchroniser; only the second stage is read by logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg  <= '0;
      end else begin
         sync1_reg <= {~ext_reset_n, ~ext_irq_n, ~kbd_n, tick_rollover, bus_activity,
                       cfg_reg[SESM_CFG_TRIP_SEL] ? supply_below_fall_5v : supply_below_fall_3v,
                       cfg_reg[SESM_CFG_TRIP_SEL] ? supply_above_rise_5v : supply_above_rise_3v};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // Decoded synchronised events; active-low pins inverted so falls become rises
   assign rst_s    = sync2_reg[SYNC_W-1];
   assign irq_fall = sync2_reg[SYNC_W-2] & ~prev_reg[SYNC_W-2];
   assign kbd_fall = |(sync2_reg[SYNC_W-3 -: KBD_W] & ~prev_reg[SYNC_W-3 -: KBD_W]);
   assign tick_s   = sync2_reg[3] & ~prev_reg[3];
   assign bus_s    = sync2_reg[2] & ~prev_reg[2] & cfg_reg[SESM_CFG_CAN_WAKE];
   assign below_s  = sync2_reg[1];
   assign above_s  = sync2_reg[0];
   assign any_reset = rst_s | supply_reset_reg;
   assign evt_now  = {supply_reset_reg & below_s, bus_s, tick_s, kbd_fall, irq_fall, rst_s};
   assign wake     = rst_s | irq_fall | kbd_fall | tick_s | bus_s | supply_reset_reg;

   // Supply monitor: flag and reset hold with hysteresis; the reset reaches irq through event bit 5
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_low_flag_reg <= 1'b0;
         supply_reset_reg    <= 1'b0;
      end else if (rst_s) begin
         supply_low_flag_reg <= 1'b0;
         supply_reset_reg    <= 1'b0;
      end else if (below_s) begin
         supply_low_flag_reg <= 1'b1;
         supply_reset_reg    <= 1'b1;
      end else if (above_s) begin
         supply_low_flag_reg <= 1'b0;
         supply_reset_reg    <= 1'b0;
      end
   end

   // Vector priority: reset sources first, then interrupt order
   always_comb begin
      vec_next = vec_reg;
      if (any_reset) begin
         vec_next = SESM_VEC_RESET;
      end else if (irq_fall) begin
         vec_next = SESM_VEC_IRQ;
      end else if (kbd_fall) begin
         vec_next = SESM_VEC_KBD;
      end else if (tick_s) begin
         vec_next = SESM_VEC_TICK;
      end else if (bus_s) begin
         vec_next = SESM_VEC_BUS;
      end
   end

   // Stop sequencer; reset sources hold the recovery counter loaded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= SESM_RUN;
         rec_cnt_reg <= '0;
         vec_reg     <= SESM_VEC_RESET;
         vector_load <= 1'b0;
      end else begin
         vector_load <= 1'b0;
         case (state_reg)
            SESM_RUN: begin
               if (stop_req) begin
                  state_reg <= SESM_STOP;
               end
            end
            SESM_STOP: begin
               if (wake) begin
                  state_reg   <= SESM_RECOVER;
                  vec_reg     <= vec_next;
                  rec_cnt_reg <= rec_load(cfg_reg[SESM_CFG_SHORT_REC]);
               end
            end
            SESM_RECOVER: begin
               if (any_reset) begin
                  rec_cnt_reg <= rec_load(cfg_reg[SESM_CFG_SHORT_REC]);
               end else if (rec_cnt_reg == '0) begin
                  state_reg   <= SESM_RUN;
                  vector_load <= 1'b1;
               end else begin
                  rec_cnt_reg <= rec_cnt_reg - 1'b1;
               end
            end
            default: begin
               state_reg <= SESM_RUN;
            end
         endcase
      end
   end

   // Registered CPU-side outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_reset     <= 1'b1;
         sys_clk_en    <= 1'b0;
         vector_addr   <= SESM_VEC_RESET;
         osc_run       <= 1'b0;
         pll_run       <= 1'b0;
         bus_rx_enable <= 1'b0;
      end else begin
         sys_reset     <= any_reset;
         sys_clk_en    <= (state_reg == SESM_RUN) && !any_reset;
         vector_addr   <= vec_reg;
         osc_run       <= osc_enable_req | cfg_reg[SESM_CFG_OSC_STOP];
         pll_run       <= osc_enable_req;
         bus_rx_enable <= (state_reg == SESM_RUN);
      end
   end

   // APB decode; zero-wait slave, unmapped offsets answer with an error
   assign apb_wr  = psel & penable & pwrite;
   assign apb_rd  = psel & penable & ~pwrite;
   assign addr_ok = (paddr == SESM_OFS_CONFIG) || (paddr == SESM_OFS_CONTROL) ||
                    (paddr == SESM_OFS_STATUS) || (paddr == SESM_OFS_EVENT) ||
                    (paddr == SESM_OFS_MASK) || (paddr == SESM_OFS_VECTOR);

   // Config and mask; is software's duty, hardware does not police the crystal case
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg  <= SESM_CFG_RESET;
         mask_reg <= SESM_EVT_RESET;
      end else if (apb_wr && paddr == SESM_OFS_CONFIG) begin
         cfg_reg  <= pwdata[3:0];
      end else if (apb_wr && paddr == SESM_OFS_MASK) begin
         mask_reg <= pwdata[SESM_EVT_W-1:0];
      end
   end

   // Sticky wake events; a new event wins over the read clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_reg <= SESM_EVT_RESET;
      end else if (apb_rd && paddr == SESM_OFS_EVENT) begin
         evt_reg <= evt_now;
      end else begin
         evt_reg <= evt_reg | evt_now;
      end
   end

   // Read data, ready and error, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         irq     <= |(evt_reg & mask_reg);
         prdata  <= '0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               SESM_OFS_CONFIG:  prdata <= {28'h000_0000, cfg_reg};
               SESM_OFS_STATUS:  prdata <= {24'h00_0000, supply_low_flag_reg, 7'h00};
               SESM_OFS_EVENT:   prdata <= {26'h000_0000, evt_reg};
               SESM_OFS_MASK:    prdata <= {26'h000_0000, mask_reg};
               SESM_OFS_VECTOR:  prdata <= {16'h0000, vec_reg};
               SESM_OFS_CONTROL: prdata <= {30'h0000_0000, state_reg};
               default:          prdata <= '0;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

/* dv/sesm_supply_model.sv */
// Supply comparator model feeding the monitor trip inputs
`timescale 1ns/100ps
`default_nettype none
module sesm_supply_model #(
   parameter int FALL5 = 4200,
   parameter int RISE5 = 4500,
   parameter int FALL3 = 2600,
   parameter int RISE3 = 2900
) (
   // Supply level in millivolts
   input  var int   supply_mv,
   // Comparator levels
   output logic     supply_below_fall_5v,
   output logic     supply_above_rise_5v,
   output logic     supply_below_fall_3v,
   output logic     supply_above_rise_3v
);
   // Rise above fall by a hysteresis gap, so between both is quiet
   assign supply_below_fall_5v = supply_mv < FALL5;
   assign supply_above_rise_5v = supply_mv > RISE5;
   assign supply_below_fall_3v = supply_mv < FALL3;
   assign supply_above_rise_3v = supply_mv > RISE3;
endmodule
`default_nettype wire

/* dv/sesm_stop_exit_asserts.sv */
// Concurrent checks on the stop-exit sequencer ports
`timescale 1ns/100ps
`default_nettype none
module sesm_stop_exit_asserts #(
   parameter int REC_SHORT = 32
) (
   // Clock, reset and inputs
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ext_reset_n,
   input wire logic supply_below_fall_5v,
   input wire logic supply_below_fall_3v,
   input wire logic osc_enable_req,
   // Outputs watched
   input wire logic osc_run,
   input wire logic pll_run,
   input wire logic sys_reset,
   input wire logic sys_clk_en,
   input wire logic vector_load,
   input wire logic bus_rx_enable
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [15:0] off_cnt;
   // Run length of gated clocks, saturating so long stops cannot wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) off_cnt <= '0;
      else if (sys_clk_en) off_cnt <= '0;
      else if (off_cnt != 16'hFFFF) off_cnt <= off_cnt + 16'h0001;
   end
   sequence s_ext_low; !ext_reset_n [*4]; endsequence
   sequence s_supply_low; (supply_below_fall_5v && supply_below_fall_3v) [*4]; endsequence
   sequence s_load_end; !vector_load ##0 sys_clk_en; endsequence
   a_osc_on_req: assert property (osc_enable_req |=> osc_run)
      else $error("oscillator off while requested");
   a_pll_tracks: assert property (1 |=> pll_run == $past(osc_enable_req))
      else $error("loop enable does not track request");
   a_load_resume: assert property (vector_load |=> s_load_end)
      else $error("vector load not a single pulse before clocks");
   a_ext_reset: assert property (s_ext_low |-> sys_reset)
      else $error("reset pin low but no reset");
   a_supply_trip: assert property (s_supply_low |-> sys_reset)
      else $error("supply low but no reset");
   a_rx_quiet: assert property (vector_load |-> !bus_rx_enable)
      else $error("bus receive enabled before recovery end");
   a_rec_min: assert property (vector_load |-> off_cnt >= REC_SHORT)
      else $error("recovery shorter than short count");
   a_load_no_rst: assert property (vector_load |-> !sys_reset)
      else $error("vector load during reset");
endmodule
bind sesm_stop_exit sesm_stop_exit_asserts #(.REC_SHORT(REC_SHORT)) u_chk (.pclk, .presetn,
   .ext_reset_n, .supply_below_fall_5v, .supply_below_fall_3v, .osc_enable_req, .osc_run,
   .pll_run, .sys_reset, .sys_clk_en, .vector_load, .bus_rx_enable);
`default_nettype wire

/* dv/sesm_stop_exit_tb.sv */
// Self-checking bench for the stop-exit sequencer
`timescale 1ns/100ps
`default_nettype none
module sesm_stop_exit_tb;
   import sesm_pkg::*;
   localparam int RF = 64, RS = 8;
   logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, ext_reset_n = 1, ext_irq_n = 1, tick_rollover = 0, bus_activity = 0;
   logic stop_req = 0, osc_enable_req = 0, supply_below_fall_5v, supply_above_rise_5v;
   logic supply_below_fall_3v, supply_above_rise_3v, sys_reset, sys_clk_en, vector_load;
   logic osc_run, pll_run, bus_rx_enable, irq;
   logic [7:0] kbd_n = 8'hFF;
   logic [15:0] vector_addr;
   logic [3:0] cfg = 4'h0;
   int supply_mv = 5000, n_mismatch = 0, tests_run = 0, cyc = 0;
   sesm_supply_model u_sup (.*);
   sesm_stop_exit #(.REC_FULL(RF), .REC_SHORT(RS)) u_dut (.*);
   // Free-running clock, 8 ns period
   initial begin
      pclk = 0;
      forever #4 pclk = ~pclk;
   end
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // APB cycle; request held until the rising edge that sees pready, then released
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   function automatic logic [15:0] exp_vec(int s);
      case (s)
         1: return SESM_VEC_IRQ;
         2: return SESM_VEC_KBD;
         3: return SESM_VEC_TICK;
         4: return SESM_VEC_BUS;
         default: return SESM_VEC_RESET;
      endcase
   endfunction
   // Enter stop, wake from source s, time the recovery
   task automatic wake(int s, int rec);
      int n;
      stop_req <= 1;
      osc_enable_req <= 1'($urandom);
      @(posedge pclk);
      stop_req <= 0;
      repeat (3) @(posedge pclk);
      chk("clk_en stop", sys_clk_en, 0);
      chk("rx stop", bus_rx_enable, 0);
      chk("osc_run", osc_run, osc_enable_req | cfg[2]);
      chk("pll_run", pll_run, osc_enable_req);
      case (s)
         0: begin
            ext_reset_n <= 0;
            repeat (6) @(posedge pclk);
            ext_reset_n <= 1;
         end
         1: ext_irq_n <= 0;
         2: kbd_n[$urandom_range(7, 0)] <= 0;
         3: tick_rollover <= 1;
         default: bus_activity <= 1;
      endcase
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (vector_load !== 1'b1 && n < 5000);
      chk("vector", vector_addr, exp_vec(s));
      chk("recovery", n >= rec && n <= rec + 8, 1);
      @(posedge pclk);
      ext_irq_n <= 1;
      kbd_n <= 8'hFF;
      tick_rollover <= 0;
      bus_activity <= 0;
      repeat (4) @(posedge pclk);
      chk("rx run", bus_rx_enable, 1);
   endtask
   // Main sequence
   initial begin
      void'($urandom(32'hd801));
      repeat (3) @(posedge pclk);
      presetn <= 1;
      repeat (6) @(posedge pclk);
      chk("sys_reset", sys_reset, 0);
      apb(1, SESM_OFS_STATUS, 32'hFFFF_FFFF);
      apb(0, SESM_OFS_STATUS, 0);
      chk("flag", rd[SESM_ST_SUPPLY_LOW], 0);
      apb(0, 12'h0FC, 0);
      chk("slverr", err, 1);
      wake(0, RF);
      for (int s = 1; s < 5; s++) begin
         // Even sources act as crystal boards and keep the full count
         cfg = {3'b101, 1'(s % 2)};
         cfg[2] = 1'($urandom);
         apb(1, SESM_OFS_CONFIG, 32'(cfg));
         wake(s, s % 2 ? RS : RF);
      end
      // Sticky event, mask and read clear
      apb(0, SESM_OFS_EVENT, 0);
      apb(1, SESM_OFS_MASK, 32'h0000_0002);
      ext_irq_n <= 0;
      repeat (6) @(posedge pclk);
      chk("irq set", irq, 1);
      chk("vector run", vector_addr, SESM_VEC_BUS);
      apb(0, SESM_OFS_EVENT, 0);
      chk("event", rd[5:0], 6'h02);
      // Clear lands at the access edge, irq follows one register later
      repeat (2) @(posedge pclk);
      chk("irq clr", irq, 0);
      ext_irq_n <= 1;
      apb(1, SESM_OFS_MASK, 0);
      kbd_n <= 8'hFE;
      repeat (6) @(posedge pclk);
      chk("irq masked", irq, 0);
      // Trip level select, then hysteresis
      apb(1, SESM_OFS_CONFIG, 0);
      supply_mv <= 4000;
      repeat (6) @(posedge pclk);
      chk("3v no trip", sys_reset, 0);
      apb(1, SESM_OFS_CONFIG, 32'h0000_0002);
      supply_mv <= 2000;
      repeat (6) @(posedge pclk);
      chk("trip", sys_reset, 1);
      supply_mv <= 4400;
      repeat (6) @(posedge pclk);
      chk("hold", sys_reset, 1);
      apb(0, SESM_OFS_STATUS, 0);
      chk("flag low", rd[SESM_ST_SUPPLY_LOW], 1);
      chk("no irq", irq, 0);
      supply_mv <= 5000;
      repeat (6) @(posedge pclk);
      chk("release", sys_reset, 0);
      apb(0, SESM_OFS_STATUS, 0);
      chk("flag ok", rd[SESM_ST_SUPPLY_LOW], 0);
      final_report();
   end
endmodule
`default_nettype wire
